// ---- rtl/qsf_pkg.sv ----
// shared constants and types of the quad serial flash pin interface
package qsf_pkg;
    // clock and hardware reset timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int HW_RESET_MIN_NS   = 1000;
    localparam int HW_RESET_CYCLES   = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // widths and depths
    localparam int LANES             = 4;
    localparam int BYTE_W            = 8;
    localparam int FIFO_DEPTH        = 16;
    localparam int SYNC_W            = 7;
    // positions inside the synchroniser vector
    localparam int SY_LANE_LO        = 0;
    localparam int SY_SCLK           = 4;
    localparam int SY_CS             = 5;
    localparam int SY_RST            = 6;
    // bits per byte and step per lane width
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] STEP_W1       = 4'h1;
    localparam logic [3:0] STEP_W2       = 4'h2;
    localparam logic [3:0] STEP_W4       = 4'h4;
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    // output enable patterns per lane width
    localparam logic [3:0] OE_NONE       = 4'h0;
    localparam logic [3:0] OE_W1         = 4'h2;
    localparam logic [3:0] OE_W2         = 4'h3;
    localparam logic [3:0] OE_W4         = 4'hf;
    // byte sent when the user has nothing queued
    localparam logic [7:0] IDLE_FILL     = 8'hff;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    typedef enum logic [1:0] {QSF_W1, QSF_W2, QSF_W4} qsf_width_t;
    typedef enum logic [1:0] {QSF_ASLEEP, QSF_IDLE, QSF_ACTIVE} qsf_state_t;
endpackage : qsf_pkg

// ---- rtl/qsf_pin_if.sv ----
// pin-level serial interface of the flash device with its receive fifo
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - single lane: lane0 input, rising edge sampled
// - quad: lane0 input on writes, output reads
// - reads drive lane1, changed on falling edges
// - quad write: lane1 becomes rising edge input
// - quad fast read drives lane1 on falling
// - lanes 2,3 output only in quad reads
// - chip select high: all lanes released
// - chip select low: device selected, active
// - nothing accepted before first select falling edge
// - host clocks; device samples on rising edges
// - outputs change after falling; host captures next
// - reset low about 1us returns power-on state
// - unconnected reset input reads as high
// plain fifo of flip-flops, valid and ready on both sides
module qsf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             clr,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST  = (AW)'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    // honest flags from the fill count
    assign in_ready  = (count != FULL_CNT);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // storage, written at the write pointer
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    // pointers and fill count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clr) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : qsf_fifo
// device side of the serial pins
module qsf_pin_if #(
    parameter int HW_RESET_CNT = qsf_pkg::HW_RESET_CYCLES,
    parameter int RX_DEPTH     = qsf_pkg::FIFO_DEPTH
) (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        serial_clock_in,
    input  wire logic                        chip_select_n,
    input  wire logic                        hw_reset_n,
    input  wire logic                        hw_reset_n_driven,
    input  wire logic [qsf_pkg::LANES-1:0]   lane_in,
    output logic      [qsf_pkg::LANES-1:0]   lane_out,
    output logic      [qsf_pkg::LANES-1:0]   lane_oe,
    input  wire logic                        quad_lane_mode,
    input  wire logic                        phase_out,
    input  wire qsf_pkg::qsf_width_t         phase_width,
    input  wire logic [qsf_pkg::BYTE_W-1:0]  tx_data,
    input  wire logic                        tx_valid,
    output logic                             tx_ready,
    output logic      [qsf_pkg::BYTE_W-1:0]  rx_data,
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    output logic                             selected,
    output logic                             awake,
    output logic                             hw_reset_active,
    output logic                             frame_start,
    output logic                             overrun
);
    import qsf_pkg::*;
    localparam int RCW = $clog2(HW_RESET_CNT + 1);
    localparam logic [RCW-1:0] RST_LIMIT = RCW'(HW_RESET_CNT);
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              reset_pad;
    logic              sclk_prev;
    logic              cs_prev;
    logic              s_sclk;
    logic              s_cs_n;
    logic              s_rst_n;
    logic [LANES-1:0]  s_lanes;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              cs_fall;
    logic [RCW-1:0]    rst_cnt;
    logic              soft_rst;
    qsf_state_t        state;
    logic              active;
    qsf_width_t        eff_w;
    logic [3:0]        step;
    logic [BYTE_W-1:0] sh_in;
    logic [3:0]        in_cnt;
    logic [3:0]        next_in_cnt;
    logic [BYTE_W-1:0] next_sh_in;
    logic [BYTE_W-1:0] push_data;
    logic              push_valid;
    logic              fifo_in_ready;
    logic [BYTE_W-1:0] fifo_out_data;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [BYTE_W-1:0] sh_out;
    logic [3:0]        out_cnt;
    logic [3:0]        next_out_cnt;
    logic [BYTE_W-1:0] word;
    logic [LANES-1:0]  next_oe;
    // lanes presented for the top bits of a byte
    function automatic logic [LANES-1:0] present(input logic [BYTE_W-1:0] w,
                                                 input qsf_width_t wd);
        logic [LANES-1:0] r;
        r = '0;
        case (wd)
            QSF_W2:  r = {2'b00, w[7:6]};
            QSF_W4:  r = w[7:4];
            default: r = {2'b00, w[7], 1'b0};
        endcase
        return r;
    endfunction : present
    // byte after shifting in the lanes, most significant first
    function automatic logic [BYTE_W-1:0] shift_in(input logic [BYTE_W-1:0] s,
                                                   input logic [LANES-1:0] l,
                                                   input qsf_width_t wd);
        logic [BYTE_W-1:0] r;
        r = s;
        case (wd)
            QSF_W2:  r = {s[5:0], l[1:0]};
            QSF_W4:  r = {s[3:0], l[3:0]};
            default: r = {s[6:0], l[0]};
        endcase
        return r;
    endfunction : shift_in
    // floating reset input is taken as high
    assign reset_pad = hw_reset_n_driven ? hw_reset_n : 1'b1;
    // two flip-flops on every pin input; clock bit presets to its idle low level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= ~SYNC_W'(1 << SY_SCLK); // no false clock edge after reset
            sync2 <= ~SYNC_W'(1 << SY_SCLK);
        end else begin
            sync1 <= {reset_pad, chip_select_n, serial_clock_in, lane_in};
            sync2 <= sync1;
        end
    end
    assign s_lanes = sync2[SY_LANE_LO +: LANES];
    assign s_sclk  = sync2[SY_SCLK];
    assign s_cs_n  = sync2[SY_CS];
    assign s_rst_n = sync2[SY_RST];
    // edge detection on the synchronised clock and select
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sclk_prev <= s_sclk;
            cs_prev   <= s_cs_n;
        end
    end
    assign sclk_rise = s_sclk && !sclk_prev;
    assign sclk_fall = !s_sclk && sclk_prev;
    assign cs_fall   = !s_cs_n && cs_prev;
    // hardware reset low long enough, saturating count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt <= '0;
        end else if (s_rst_n) begin
            rst_cnt <= '0;
        end else if (rst_cnt != RST_LIMIT) begin
            rst_cnt <= rst_cnt + 1'b1;
        end
    end
    assign soft_rst = (rst_cnt == RST_LIMIT);
    // select state: asleep until the first select falling edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= QSF_ASLEEP;
        end else if (soft_rst) begin
            state <= QSF_ASLEEP;
        end else begin
            case (state)
                QSF_ASLEEP, QSF_IDLE: begin
                    if (cs_fall) begin
                        state <= QSF_ACTIVE;
                    end
                end
                QSF_ACTIVE: begin
                    if (s_cs_n) begin
                        state <= QSF_IDLE;
                    end
                end
                default: state <= QSF_ASLEEP;
            endcase
        end
    end
    assign active = (state == QSF_ACTIVE) && !s_cs_n && !soft_rst;
    // single lane mode forces one-bit traffic
    assign eff_w = quad_lane_mode ? phase_width : QSF_W1;
    always_comb begin
        case (eff_w)
            QSF_W2:  step = STEP_W2;
            QSF_W4:  step = STEP_W4;
            default: step = STEP_W1;
        endcase
    end
    // input shift on rising edges while not driving
    assign next_sh_in  = shift_in(sh_in, s_lanes, eff_w);
    assign next_in_cnt = (in_cnt + step == BITS_PER_BYTE) ? CNT_ZERO : in_cnt + step;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh_in      <= BYTE_ZERO;
            in_cnt     <= CNT_ZERO;
            push_valid <= 1'b0;
            push_data  <= BYTE_ZERO;
        end else begin
            push_valid <= 1'b0;
            if (!active) begin
                in_cnt <= CNT_ZERO;
            end else if (sclk_rise && !phase_out) begin
                sh_in  <= next_sh_in;
                in_cnt <= next_in_cnt;
                if (next_in_cnt == CNT_ZERO) begin
                    push_valid <= 1'b1;
                    push_data  <= next_sh_in;
                end
            end
        end
    end
    qsf_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .clr       (soft_rst),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );
    // registered output stage of the receive path
    assign fifo_out_ready = !rx_valid || rx_ready;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_valid <= 1'b0;
            rx_data  <= BYTE_ZERO;
        end else if (soft_rst) begin
            rx_valid <= 1'b0;
        end else if (fifo_out_ready) begin
            rx_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
                rx_data <= fifo_out_data;
            end
        end
    end
    // output shift, new bits presented after each falling edge
    assign word         = tx_valid ? tx_data : IDLE_FILL;
    assign next_out_cnt = (out_cnt + step == BITS_PER_BYTE) ? CNT_ZERO : out_cnt + step;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh_out   <= BYTE_ZERO;
            out_cnt  <= CNT_ZERO;
            lane_out <= '0;
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= 1'b0;
            if (!active || !phase_out) begin
                out_cnt <= CNT_ZERO;
            end else if (sclk_fall) begin
                out_cnt <= next_out_cnt;
                if (out_cnt == CNT_ZERO) begin
                    lane_out <= present(word, eff_w);
                    sh_out   <= word << step;
                    tx_ready <= tx_valid;
                end else begin
                    lane_out <= present(sh_out, eff_w);
                    sh_out   <= sh_out << step;
                end
            end
        end
    end
    // lane drive enables by phase and width
    always_comb begin
        next_oe = OE_NONE;
        if (active && phase_out) begin
            case (eff_w)
                QSF_W2:  next_oe = OE_W2;
                QSF_W4:  next_oe = OE_W4;
                default: next_oe = OE_W1;
            endcase
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lane_oe <= OE_NONE;
        end else begin
            lane_oe <= next_oe;
        end
    end
    // status outputs; a dropped byte wins over the clear at frame start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            selected        <= 1'b0;
            awake           <= 1'b0;
            hw_reset_active <= 1'b0;
            frame_start     <= 1'b0;
            overrun         <= 1'b0;
        end else begin
            selected        <= active;
            awake           <= (state != QSF_ASLEEP) && !soft_rst;
            hw_reset_active <= soft_rst;
            frame_start     <= cs_fall && !soft_rst;
            if (soft_rst) begin
                overrun <= 1'b0;
            end else if (push_valid && !fifo_in_ready) begin
                overrun <= 1'b1;
            end else if (cs_fall) begin
                overrun <= 1'b0;
            end
        end
    end
endmodule : qsf_pin_if
`default_nettype wire

// ---- test/qsf_pin_if_chk.sv ----
// concurrent checks on the ports of the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
module qsf_pin_if_chk #(
    parameter int HW_RESET_CNT = 25
) (
    input wire logic                      clk,
    input wire logic                      nrst,
    input wire logic                      chip_select_n,
    input wire logic                      hw_reset_n,
    input wire logic                      hw_reset_n_driven,
    input wire logic                      phase_out,
    input wire logic                      quad_lane_mode,
    input wire logic [qsf_pkg::LANES-1:0] lane_oe,
    input wire logic [qsf_pkg::BYTE_W-1:0] rx_data,
    input wire logic                      rx_valid,
    input wire logic                      rx_ready,
    input wire logic                      selected,
    input wire logic                      awake,
    input wire logic                      hw_reset_active,
    input wire logic                      frame_start
);
    import qsf_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    int low_cnt;
    // cycles the effective reset pin has stayed low, pull-up counts as high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 0;
        end else if (hw_reset_n_driven && !hw_reset_n) begin
            low_cnt <= (low_cnt < 1000) ? low_cnt + 1 : low_cnt;
        end else begin
            low_cnt <= 0;
        end
    end
    // select held high past the synchronisers, and a write phase settled
    sequence s_cs_high; chip_select_n [*4]; endsequence
    sequence s_read_off; !phase_out [*2]; endsequence
    property p_cs_off; s_cs_high |-> lane_oe == 4'h0; endproperty
    property p_write_phase; s_read_off |-> lane_oe == 4'h0; endproperty
    property p_single_lanes; !quad_lane_mode [*2] |-> lane_oe[3:2] == 2'h0; endproperty
    property p_asleep; !awake |-> lane_oe == 4'h0 && !selected; endproperty
    property p_frame; frame_start |=> !frame_start ##[0:2] selected; endproperty
    property p_hw_state; hw_reset_active |-> !rx_valid && !awake; endproperty
    property p_hw_on; low_cnt == HW_RESET_CNT + 6 |-> hw_reset_active; endproperty
    property p_pullup; !hw_reset_n_driven [*8] |-> !hw_reset_active; endproperty
    property p_rx_hold;
        rx_valid && !rx_ready && hw_reset_n |=> rx_valid && $stable(rx_data);
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("lanes driven while deselected");
    a_write_phase: assert property (p_write_phase) else $error("lane driven in input phase");
    a_single_lanes: assert property (p_single_lanes) else $error("upper lanes in single mode");
    a_asleep: assert property (p_asleep) else $error("activity before first select");
    a_frame: assert property (p_frame) else $error("frame start not followed by select");
    a_hw_state: assert property (p_hw_state) else $error("state kept in hardware reset");
    a_hw_on: assert property (p_hw_on) else $error("hardware reset not taken");
    a_pullup: assert property (p_pullup) else $error("open reset pin resets");
    a_rx_hold: assert property (p_rx_hold) else $error("received byte not held");
endmodule : qsf_pin_if_chk
bind qsf_pin_if qsf_pin_if_chk #(.HW_RESET_CNT(HW_RESET_CNT)) u_chk (
    .clk(clk), .nrst(nrst), .chip_select_n(chip_select_n), .hw_reset_n(hw_reset_n),
    .hw_reset_n_driven(hw_reset_n_driven), .phase_out(phase_out),
    .quad_lane_mode(quad_lane_mode), .lane_oe(lane_oe), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .selected(selected), .awake(awake),
    .hw_reset_active(hw_reset_active), .frame_start(frame_start));
`default_nettype wire

// ---- test/qsf_host.sv ----
// host model driving serial clock, select and data lanes
`timescale 1ns/10ps
`default_nettype none
module qsf_host (
    input  wire logic       clk,
    input  wire logic [3:0] lane_out,
    input  wire logic [3:0] lane_oe,
    output logic      [3:0] lane_in,
    output logic            sclk,
    output logic            cs_n
);
    logic [3:0] h_out = 4'h0;
    logic [3:0] h_oe  = 4'h0;
    logic       flt   = 1'b0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // a lane nobody drives flips every cycle, so stale data never matches
    always @(posedge clk) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_in[i] = lane_oe[i] ? lane_out[i] : (h_oe[i] ? h_out[i] : flt);
        end
    end
    // open and close a select frame; clock rests low between byte tasks
    task automatic open_frame();
        #13 cs_n = 1'b0;
        #400;
    endtask : open_frame
    task automatic close_frame();
        #400 cs_n = 1'b1;
        h_oe = 4'h0;
        #400;
    endtask : close_frame
    // one byte into the device, top chunk first, stable around each rise
    task automatic put_byte(input logic [7:0] b, input int w);
        int m;
        m = (1 << w) - 1;
        for (int k = 8 - w; k >= 0; k -= w) begin
            h_oe = 4'(m);
            h_out = 4'((b >> k) & m);
            #160 sclk = 1'b1;
            #160 sclk = 1'b0;
        end
    endtask : put_byte
    // lanes released first; each chunk is captured just before the next fall
    task automatic get_byte(input int w, output logic [7:0] b);
        logic [3:0] s;
        h_oe = 4'h0;
        b = 8'h00;
        for (int k = 0; k <= 8 / w; k++) begin
            sclk = 1'b1;
            #160 s = (w == 1) ? {3'h0, lane_in[1]} : lane_in & 4'((1 << w) - 1);
            if (k > 0) b = 8'((b << w) | s);
            sclk = 1'b0;
            #160;
        end
    endtask : get_byte
endmodule : qsf_host
`default_nettype wire

// ---- test/qsf_pin_if_test.sv ----
// self-checking bench of the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
module qsf_pin_if_test;
    import qsf_pkg::*;
    localparam int RST_CNT = 4;
    logic       clk = 1'b0, nrst = 1'b0, hw_n = 1'b1, hw_drv = 1'b1;
    logic       quad = 1'b0, ph_out = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic       sclk, cs_n, tx_ready, rx_valid, selected, awake, hw_act, fstart, overrun;
    logic [3:0] lane_in, lane_out, lane_oe;
    logic [7:0] tx_data = 8'h00, rx_data;
    qsf_width_t ph_w = QSF_W1;
    qsf_width_t wt [3] = '{QSF_W4, QSF_W2, QSF_W1};
    int         wn [3] = '{4, 2, 1};
    int         errors = 0, cmp_count = 0;
    int         tx_pulses = 0, frames = 0;
    qsf_pin_if #(.HW_RESET_CNT(RST_CNT)) dut (
        .clk(clk), .nrst(nrst), .serial_clock_in(sclk), .chip_select_n(cs_n),
        .hw_reset_n(hw_n), .hw_reset_n_driven(hw_drv), .lane_in(lane_in),
        .lane_out(lane_out), .lane_oe(lane_oe), .quad_lane_mode(quad),
        .phase_out(ph_out), .phase_width(ph_w), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .selected(selected), .awake(awake), .hw_reset_active(hw_act),
        .frame_start(fstart), .overrun(overrun));
    qsf_host u_host (.clk(clk), .lane_out(lane_out), .lane_oe(lane_oe),
        .lane_in(lane_in), .sclk(sclk), .cs_n(cs_n));
    initial begin
        forever #20 clk = ~clk;
    end
    // count one-cycle pulses that no scenario waits on directly
    always @(posedge clk) begin
        if (tx_ready === 1'b1) tx_pulses++;
        if (fstart === 1'b1) frames++;
    end
    // compare helpers, flags widened so an unknown still mismatches
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_flag(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask : chk_flag
    // user side settings change only between frames
    task automatic mode(input logic q, input logic o, input qsf_width_t w,
                        input logic [7:0] d, input logic v);
        @(posedge clk);
        quad <= q;
        ph_out <= o;
        ph_w <= w;
        tx_data <= d;
        tx_valid <= v;
    endtask : mode
    // wait a bounded time for a byte, check it and take it
    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rx_valid !== 1'b1 && n < 400);
        chk_flag(rx_valid, 1'b1);
        chk_byte(rx_data, exp);
        @(posedge clk) rx_ready <= 1'b1;
        @(posedge clk) rx_ready <= 1'b0;
    endtask : pop
    task automatic write_one(input logic [7:0] b, input int w);
        u_host.open_frame();
        u_host.put_byte(b, w);
        u_host.close_frame();
    endtask : write_one
    // clocks with select never lowered since reset
    task automatic t_asleep();
        #13 u_host.put_byte(8'h77, 1);
        repeat (8) @(posedge clk);
        chk_flag(awake, 1'b0);
        chk_flag(rx_valid, 1'b0);
        chk_byte({4'h0, lane_oe}, 8'h00);
        $display("test asleep done");
    endtask : t_asleep
    task automatic t_single();
        logic [7:0] b;
        int         n0, f0;
        f0 = frames;
        mode(1'b0, 1'b0, QSF_W1, 8'h00, 1'b0);
        u_host.open_frame();
        u_host.put_byte(8'ha5, 1);
        u_host.put_byte(8'h3c, 1);
        u_host.close_frame();
        pop(8'ha5);
        pop(8'h3c);
        chk_flag(awake, 1'b1);
        mode(1'b0, 1'b1, QSF_W1, 8'h96, 1'b1);
        n0 = tx_pulses;
        u_host.open_frame();
        u_host.get_byte(1, b);
        u_host.close_frame();
        chk_byte(b, 8'h96);
        chk_byte(8'(tx_pulses - n0), 8'h02);
        chk_byte(8'(frames - f0), 8'h02);
        chk_byte({4'h0, lane_oe}, 8'h00);
        $display("test single lane done");
    endtask : t_single
    // every lane width in both directions; last read has nothing queued
    task automatic t_quad();
        logic [7:0] b;
        logic [7:0] d [3] = '{8'h69, 8'hb4, 8'h3e};
        int         n0;
        for (int i = 0; i < 3; i++) begin
            mode(1'b1, 1'b0, wt[i], 8'h00, 1'b0);
            write_one(d[i] ^ 8'hff, wn[i]);
            pop(d[i] ^ 8'hff);
            mode(1'b1, 1'b1, wt[i], d[i], 1'(i != 2));
            n0 = tx_pulses;
            u_host.open_frame();
            u_host.get_byte(wn[i], b);
            u_host.close_frame();
            chk_byte(b, (i != 2) ? d[i] : IDLE_FILL);
            chk_byte(8'(tx_pulses - n0), (i != 2) ? 8'h02 : 8'h00);
        end
        $display("test quad lane done");
    endtask : t_quad
    // fill the receive path past capacity while nothing is taken
    task automatic t_overrun();
        mode(1'b1, 1'b0, QSF_W4, 8'h00, 1'b0);
        u_host.open_frame();
        for (int i = 0; i < 18; i++) u_host.put_byte(8'(8'h10 + i), 4);
        u_host.close_frame();
        chk_flag(overrun, 1'b1);
        for (int i = 0; i < 17; i++) pop(8'(8'h10 + i));
        @(negedge clk);
        chk_flag(rx_valid, 1'b0);
        $display("test overrun done");
    endtask : t_overrun
    // pending byte lost in hardware reset; open pin leaves device running
    task automatic t_hw_reset();
        write_one(8'he7, 4);
        @(posedge clk) hw_n <= 1'b0;
        repeat (RST_CNT + 8) @(posedge clk);
        chk_flag(hw_act, 1'b1);
        chk_flag(rx_valid, 1'b0);
        chk_flag(awake, 1'b0);
        hw_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk_flag(hw_act, 1'b0);
        hw_drv <= 1'b0;
        hw_n <= 1'b0;
        repeat (RST_CNT + 20) @(posedge clk);
        chk_flag(hw_act, 1'b0);
        write_one(8'h4b, 4);
        pop(8'h4b);
        $display("test hardware reset done");
    endtask : t_hw_reset
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    // watchdog well beyond the expected run of about 1300 cycles
    initial begin
        #400000;
        errors++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_asleep();
        t_single();
        t_quad();
        t_overrun();
        t_hw_reset();
        conclude();
    end
endmodule : qsf_pin_if_test
`default_nettype wire
